// ==== rtl/osc_pkg.sv ====
`default_nettype none
package osc_pkg;
  // register byte offsets on the apb bus
  localparam logic [11:0] REFCLK_CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] OSC_CTRL_OFFSET      = 12'h004;
  localparam logic [11:0] IRQ_STATUS_OFFSET    = 12'h008;
  localparam logic [11:0] IRQ_ENABLE_OFFSET    = 12'h00c;
  localparam logic [11:0] IRQ_CLEAR_OFFSET     = 12'h010;
  localparam logic [11:0] CONFIG_OFFSET        = 12'h014;
  // field positions
  localparam int REFCLK_OE_BIT   = 6;
  localparam int FREQ_SEL_LSB    = 4;
  localparam int HF_READY_BIT    = 3;
  localparam int LF_READY_BIT    = 1;
  localparam int HF_STABLE_BIT   = 0;
  localparam int CLK_SRC_BIT     = 0;
  // reset values
  localparam logic [2:0] FREQ_SEL_RESET  = 3'h6;
  localparam logic       REFCLK_OE_RESET = 1'b0;
  localparam logic       CLK_SRC_RESET   = 1'b0;
  // frequency codes
  localparam logic [2:0] FREQ_LF_31K = 3'h0;
  localparam logic [2:0] FREQ_16M    = 3'h7;
  // interrupt status layout
  localparam int IRQ_HF_READY  = 0;
  localparam int IRQ_LF_READY  = 1;
  localparam int IRQ_HF_STABLE = 2;
  localparam int IRQ_WIDTH     = 3;
  // source select encodings
  typedef enum logic {src_internal_type, src_external_type} clk_src_type;
endpackage : osc_pkg
`default_nettype wire

// ==== rtl/osc_source_select_ctrl.sv ====
// Summary of operation
// - refclk_out_enable drives reference pin, overriding direction
// - internal_osc_mode_freq_select picks divider tap or 31k
// - frequency select resets to 8 MHz code
// - hf_osc_ready in bit 3, reset zero
// - lf_osc_ready in bit 1, reset zero
// - hf_osc_stable in bit 0, reset zero
// - unimplemented bits always read zero
// - external mode uses clock input pin level
// - clock_source_select one picks external mode
// - divider switching has no start-up delay
// - stable rises with ready or later, never before it
// - all internal rates from two oscillators
`default_nettype none
module osc_source_select_ctrl #(
  parameter int DIV_WIDTH = 6
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        hf_osc_clk,        // 16 MHz oscillator, asynchronous level
  input  wire logic        hf_secondary_up,   // fast secondary clock running
  input  wire logic        hf_primary_locked, // accurate primary clock locked
  input  wire logic        lf_osc_clk,        // 31 kHz oscillator
  input  wire logic        lf_osc_up,         // low-frequency oscillator running
  input  wire logic        clock_input_pin,   // external logic-level clock
  input  wire logic        pin_direction_control, // 1 = pin is input
  input  wire logic        gpio_out,          // port latch value for the pin
  output logic             reference_clock_pin_o,
  output logic             reference_clock_pin_oe_n,
  output logic             system_clock,      // selected system clock level
  output logic             clock_input_is_gpio,
  output logic             irq
);

  // synchroniser stages: first flops only feed second flops
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic       hf_clk_s;                       // synced hf oscillator level
  logic       hf_up_s;                        // synced secondary running flag
  logic       hf_lock_s;                      // synced primary lock flag
  logic       lf_clk_s;                       // synced lf oscillator level
  logic       lf_up_s;                        // synced lf running flag
  logic       ext_clk_s;                      // synced external clock level
  logic       hf_clk_d_reg;                   // for edge detection on the synced hf clock

  // software state
  localparam int IRQ_WIDTH_L = osc_pkg::IRQ_WIDTH;
  logic       refclk_out_enable_reg;
  logic [2:0] internal_osc_mode_freq_select_reg;
  logic       clock_source_select_reg;
  logic [IRQ_WIDTH_L-1:0] irq_status_reg;
  logic [IRQ_WIDTH_L-1:0] irq_enable_reg;
  logic [IRQ_WIDTH_L-1:0] irq_status_next;

  // oscillator state flags and their previous values
  logic       hf_ready_reg;                   // secondary clock ready, software view
  logic       lf_ready_reg;                   // lf oscillator ready, software view
  logic       hf_stable_reg;                  // primary clock stable, software view
  logic       hf_ready_d_reg;                 // previous values, for rising-edge events
  logic       lf_ready_d_reg;
  logic       hf_stable_d_reg;

  // divider built from the high-frequency oscillator
  logic [DIV_WIDTH-1:0] div_reg;
  logic       int_clock;
  logic       system_clock_next;

  // apb decode
  logic       wr_en;
  logic       rd_en;
  logic       addr_hit;
  logic [7:0] rd_byte;

  // unpack the second stage; only these copies feed any logic
  assign {hf_clk_s, hf_up_s, hf_lock_s, lf_clk_s, lf_up_s, ext_clk_s} = sync2_reg;

  // two-flop synchronisers for every asynchronous input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
    end else begin
      sync1_reg <= {hf_osc_clk, hf_secondary_up, hf_primary_locked,
                    lf_osc_clk, lf_osc_up, clock_input_pin};
      sync2_reg <= sync1_reg;
    end
  end

  // oscillator status flags; stable only with ready so the order is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hf_ready_reg  <= 1'b0;
      lf_ready_reg  <= 1'b0;
      hf_stable_reg <= 1'b0;
    end else begin
      hf_ready_reg  <= hf_up_s;
      lf_ready_reg  <= lf_up_s;
      hf_stable_reg <= hf_up_s & hf_lock_s;
    end
  end

  // previous flag values for rising-edge events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hf_ready_d_reg  <= 1'b0;
      lf_ready_d_reg  <= 1'b0;
      hf_stable_d_reg <= 1'b0;
      hf_clk_d_reg    <= 1'b0;
    end else begin
      hf_ready_d_reg  <= hf_ready_reg;
      lf_ready_d_reg  <= lf_ready_reg;
      hf_stable_d_reg <= hf_stable_reg;
      hf_clk_d_reg    <= hf_clk_s;
    end
  end

  // free-running divider on the hf oscillator edges; taps only, so no restart on change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= '0;
    end else if (hf_clk_s && !hf_clk_d_reg) begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // tap select: code 7 is the raw oscillator, codes 6 down to 1 halve each step, code 0 is the lf oscillator
  always_comb begin
    // codes 6 down to 1 pick divider bits 0 up to 5, so each step halves the rate
    case (internal_osc_mode_freq_select_reg)
      osc_pkg::FREQ_LF_31K: int_clock = lf_clk_s;
      osc_pkg::FREQ_16M:    int_clock = hf_clk_s;
      default: int_clock = div_reg[3'h6 - internal_osc_mode_freq_select_reg];
    endcase
  end

  // external mode bypasses the field entirely, which keeps its value for later
  assign system_clock_next = clock_source_select_reg ? ext_clk_s : int_clock;

  // registered clock outputs
  // with the output enabled both load from one source, so the pin copy stays in phase with the system clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_clock          <= 1'b0;
      reference_clock_pin_o <= 1'b0;
    end else begin
      system_clock          <= system_clock_next;
      reference_clock_pin_o <= refclk_out_enable_reg ? system_clock_next : gpio_out;
    end
  end

  // pin driven when output enable set, whatever the direction control says
  assign reference_clock_pin_oe_n = !(refclk_out_enable_reg || !pin_direction_control);
  assign clock_input_is_gpio = !clock_source_select_reg;

  // apb: zero wait states, every access answered in its access cycle
  assign pready   = 1'b1;
  assign addr_hit = (paddr == osc_pkg::REFCLK_CTRL_OFFSET) ||
                    (paddr == osc_pkg::OSC_CTRL_OFFSET)    ||
                    (paddr == osc_pkg::IRQ_STATUS_OFFSET)  ||
                    (paddr == osc_pkg::IRQ_ENABLE_OFFSET)  ||
                    (paddr == osc_pkg::IRQ_CLEAR_OFFSET)   ||
                    (paddr == osc_pkg::CONFIG_OFFSET);
  // unmapped places answer with an error and leave every register alone
  assign pslverr  = psel && penable && !addr_hit;
  assign wr_en    = psel && penable && pwrite && pstrb[0] && addr_hit;
  assign rd_en    = psel && penable && !pwrite;

  // software writable control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refclk_out_enable_reg   <= osc_pkg::REFCLK_OE_RESET;
      internal_osc_mode_freq_select_reg  <= osc_pkg::FREQ_SEL_RESET;
      clock_source_select_reg <= osc_pkg::CLK_SRC_RESET;
      irq_enable_reg          <= '0;
    end else if (wr_en) begin
      case (paddr)
        osc_pkg::REFCLK_CTRL_OFFSET:
          refclk_out_enable_reg <= pwdata[osc_pkg::REFCLK_OE_BIT];
        osc_pkg::OSC_CTRL_OFFSET:
          internal_osc_mode_freq_select_reg <= pwdata[osc_pkg::FREQ_SEL_LSB +: 3];
        osc_pkg::CONFIG_OFFSET:
          clock_source_select_reg <= pwdata[osc_pkg::CLK_SRC_BIT];
        osc_pkg::IRQ_ENABLE_OFFSET:
          irq_enable_reg <= pwdata[IRQ_WIDTH_L-1:0];
        // status and clear hold no storage of their own here
        default: ;
      endcase
    end
  end

  // sticky events: a new rise wins over a same-cycle clear
  always_comb begin
    irq_status_next = irq_status_reg;
    if (wr_en && paddr == osc_pkg::IRQ_CLEAR_OFFSET) begin
      irq_status_next = irq_status_next & ~pwdata[IRQ_WIDTH_L-1:0];
    end
    if (hf_ready_reg && !hf_ready_d_reg) begin
      irq_status_next[osc_pkg::IRQ_HF_READY] = 1'b1;
    end
    if (lf_ready_reg && !lf_ready_d_reg) begin
      irq_status_next[osc_pkg::IRQ_LF_READY] = 1'b1;
    end
    if (hf_stable_reg && !hf_stable_d_reg) begin
      irq_status_next[osc_pkg::IRQ_HF_STABLE] = 1'b1;
    end
  end

  // status register
  // one flop per event; the next value already merges set and clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  // level interrupt
  // built from the next status so a new event raises irq with no extra lag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_next & irq_enable_reg);
    end
  end

  // read mux; unimplemented bits are zero
  always_comb begin
    rd_byte = 8'h00;
    case (paddr)
      osc_pkg::REFCLK_CTRL_OFFSET:
        rd_byte[osc_pkg::REFCLK_OE_BIT] = refclk_out_enable_reg;
      osc_pkg::OSC_CTRL_OFFSET: begin
        rd_byte[osc_pkg::FREQ_SEL_LSB +: 3] = internal_osc_mode_freq_select_reg;
        rd_byte[osc_pkg::HF_READY_BIT]      = hf_ready_reg;
        rd_byte[osc_pkg::LF_READY_BIT]      = lf_ready_reg;
        rd_byte[osc_pkg::HF_STABLE_BIT]     = hf_stable_reg;
      end
      // the clear register is write-only and falls to the default zero
      osc_pkg::IRQ_STATUS_OFFSET: rd_byte[IRQ_WIDTH_L-1:0] = irq_status_reg;
      osc_pkg::IRQ_ENABLE_OFFSET: rd_byte[IRQ_WIDTH_L-1:0] = irq_enable_reg;
      osc_pkg::CONFIG_OFFSET:     rd_byte[osc_pkg::CLK_SRC_BIT] = clock_source_select_reg;
      default: rd_byte = 8'h00;
    endcase
  end

  // read data from a flop, loaded in the setup cycle so it is valid at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h00_0000, rd_byte};
    end
  end

  // assertions, all on the bus clock and idle while reset is low
  // an enabled reference output always owns the pin
  AST_OE_DRIVES: assert property (@(posedge pclk) disable iff (!presetn)
    refclk_out_enable_reg |-> !reference_clock_pin_oe_n)
    else $error("reference pin not driven while enabled");

  // with the output off, a pin set as input stays undriven
  AST_OE_RELEASE: assert property (@(posedge pclk) disable iff (!presetn)
    !refclk_out_enable_reg && pin_direction_control |-> reference_clock_pin_oe_n)
    else $error("reference pin driven while disabled");

  // the pin copy carries the same clock as the system output
  AST_PIN_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn)
    refclk_out_enable_reg |=> reference_clock_pin_o == system_clock)
    else $error("reference pin not carrying the clock");

  // external mode passes the synced pin level straight through
  AST_SYS_EXT: assert property (@(posedge pclk) disable iff (!presetn)
    clock_source_select_reg && $stable(clock_source_select_reg)
    |=> system_clock == $past(ext_clk_s))
    else $error("external clock not followed");

  // the input pin is free for general use only in internal mode
  AST_GPIO_FREE: assert property (@(posedge pclk) disable iff (!presetn)
    clock_input_is_gpio == !clock_source_select_reg)
    else $error("pin role wrong");

  // the accurate clock never reports before the fast one
  AST_STABLE_AFTER_READY: assert property (@(posedge pclk) disable iff (!presetn)
    hf_stable_reg |-> hf_ready_reg)
    else $error("stable before ready");

  // a running lf oscillator shows up one cycle later
  AST_LF_READY: assert property (@(posedge pclk) disable iff (!presetn)
    lf_up_s |=> lf_ready_reg)
    else $error("lf ready not reported");

  // a stopped lf oscillator drops its flag one cycle later
  AST_LF_DOWN: assert property (@(posedge pclk) disable iff (!presetn)
    !lf_up_s |=> !lf_ready_reg)
    else $error("lf ready kept without oscillator");

  // a running secondary clock shows up one cycle later
  AST_HF_READY: assert property (@(posedge pclk) disable iff (!presetn)
    hf_up_s |=> hf_ready_reg)
    else $error("hf ready not reported");

  // the ready flag never claims more than the synced input says
  AST_READY_NEEDS_UP: assert property (@(posedge pclk) disable iff (!presetn)
    hf_ready_reg |-> $past(hf_up_s))
    else $error("hf ready without secondary clock");

  // stable needs a locked primary in the cycle before
  AST_STABLE_NEEDS_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
    hf_stable_reg |-> $past(hf_lock_s))
    else $error("hf stable without lock");

  // read data carries nothing above the implemented bits
  AST_RD_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en |-> prdata[31:8] == 24'h0 && prdata[7] == 1'b0)
    else $error("unimplemented bits nonzero");

  // code 0 hands the lf oscillator to the system clock
  AST_LF_TAP: assert property (@(posedge pclk) disable iff (!presetn)
    !clock_source_select_reg && internal_osc_mode_freq_select_reg == osc_pkg::FREQ_LF_31K
    |=> system_clock == $past(lf_clk_s))
    else $error("31k tap wrong");

  // code 7 hands the raw hf oscillator to the system clock
  AST_HF_TAP: assert property (@(posedge pclk) disable iff (!presetn)
    !clock_source_select_reg && internal_osc_mode_freq_select_reg == osc_pkg::FREQ_16M
    |=> system_clock == $past(hf_clk_s))
    else $error("16 MHz tap wrong");

  // code 6 takes the first divider stage, half the hf rate
  AST_HALF_TAP: assert property (@(posedge pclk) disable iff (!presetn)
    !clock_source_select_reg && internal_osc_mode_freq_select_reg == 3'h6
    |=> system_clock == $past(div_reg[0]))
    else $error("8 MHz tap wrong");

  // the divider only moves on an hf edge, never on a code change
  AST_DIV_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    !(hf_clk_s && !hf_clk_d_reg) |=> $stable(div_reg))
    else $error("divider moved without oscillator edge");

  // the frequency field changes only by its own write
  AST_FREQ_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_en && paddr == osc_pkg::OSC_CTRL_OFFSET) |=> $stable(internal_osc_mode_freq_select_reg))
    else $error("frequency field changed without write");

endmodule : osc_source_select_ctrl
`default_nettype wire

// ==== verification/ext_clock_source.sv ====
`default_nettype none
module ext_clock_source #(
  parameter int HALF = 4 // pclk cycles per half period of the external clock
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,            // high while the source is switched on
  output var  logic clock_input_pin // logic-level clock into the device
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt; // half-period counter
  // a stopped source stands still low, so stale edges never leak into a count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt             <= 0;
      clock_input_pin <= 1'b0;
    end else if (!run) begin
      cnt             <= 0;
      clock_input_pin <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt             <= 0;
      clock_input_pin <= ~clock_input_pin;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : ext_clock_source
`default_nettype wire

// ==== verification/tb_osc_source_select_ctrl.sv ====
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_osc_source_select_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, run;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        hf_secondary_up, hf_primary_locked, lf_osc_up, pin_dir, clk_in;
  logic        pin_o, pin_oe_n, system_clock, is_gpio, irq, err, gpio;
  logic [7:0]  div_cnt;   // free divider making the two oscillator levels
  int          error_cnt, samples_checked, cyc, cnt, exp_cnt;
  // oscillators: hf is pclk/4, lf is pclk/32
  always @(posedge pclk) div_cnt <= div_cnt + 8'h01;
  osc_source_select_ctrl osc_source_select_ctrl_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hf_osc_clk(div_cnt[1]), .hf_secondary_up(hf_secondary_up),
    .hf_primary_locked(hf_primary_locked), .lf_osc_clk(div_cnt[4]), .lf_osc_up(lf_osc_up),
    .clock_input_pin(clk_in), .pin_direction_control(pin_dir), .gpio_out(gpio),
    .reference_clock_pin_o(pin_o), .reference_clock_pin_oe_n(pin_oe_n),
    .system_clock(system_clock), .clock_input_is_gpio(is_gpio), .irq(irq));
  ext_clock_source ext_clock_source_i (.pclk(pclk), .presetn(presetn), .run(run),
    .clock_input_pin(clk_in));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // hang guard: whole sequence needs well under this
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic final_report();
    if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // one apb transfer; answer taken at the edge where pready is seen high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rdat, e)
  endtask : rd
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : wait_cyc
  // counts rising edges of the selected system clock over n cycles
  task automatic rises(input int n);
    logic prev;
    cnt  = 0;
    prev = system_clock;
    repeat (n) begin
      @(posedge pclk);
      if (system_clock === 1'b1 && prev === 1'b0) cnt++;
      prev = system_clock;
    end
  endtask : rises
  initial begin
    {presetn, psel, penable, pwrite, run, hf_secondary_up} = '0;
    {hf_primary_locked, lf_osc_up} = '0;
    {paddr, pwdata, div_cnt} = '0;
    pin_dir = 1'b1;
    gpio    = 1'b1;
    wait_cyc(20);
    presetn <= 1'b1;
    // reset values, unimplemented bits low
    rd(12'h000, 32'h0);
    rd(12'h004, 32'h60);
    rd(12'h014, 32'h0);
    `CHK(is_gpio, 1'b1)
    // reference clock drives the pin although direction says input
    xfer(1'b1, 12'h000, 32'hff);
    rd(12'h000, 32'h40);
    `CHK(pin_oe_n, 1'b0)
    repeat (16) begin
      @(posedge pclk);
      `CHK(pin_o, system_clock)
    end
    xfer(1'b1, 12'h000, 32'h0);
    wait_cyc(2);
    `CHK(pin_oe_n, 1'b1)
    `CHK(pin_o, gpio)
    pin_dir <= 1'b0;
    wait_cyc(1);
    `CHK(pin_oe_n, 1'b0)
    pin_dir <= 1'b1;
    // unmapped place is refused and reads zero
    rd(12'h020, 32'h0);
    `CHK(err, 1'b1)
    // fast secondary first, accurate primary later
    hf_secondary_up <= 1'b1;
    wait_cyc(5);
    rd(12'h004, 32'h68);
    lf_osc_up         <= 1'b1;
    hf_primary_locked <= 1'b1;
    wait_cyc(5);
    rd(12'h004, 32'h6b);
    // events: sticky status, masked, enabled, cleared
    rd(12'h008, 32'h7);
    `CHK(irq, 1'b0)
    xfer(1'b1, 12'h00c, 32'h7);
    wait_cyc(2);
    `CHK(irq, 1'b1)
    xfer(1'b1, 12'h010, 32'h7);
    wait_cyc(2);
    rd(12'h008, 32'h0);
    `CHK(irq, 1'b0)
    rd(12'h010, 32'h0);
    // every frequency code; taps switch at once with no start-up wait
    for (int c = 7; c >= 0; c--) begin
      xfer(1'b1, 12'h004, 32'(c) << 4);
      rd(12'h004, (32'(c) << 4) | 32'hb);
      rises(256);
      exp_cnt = (c == 0) ? 8 : (64 >> (7 - c));
      `CHK(cnt >= exp_cnt - 1 && cnt <= exp_cnt + 1, 1'b1)
    end
    // external mode follows the pin and ignores the frequency field
    xfer(1'b1, 12'h014, 32'h1);
    wait_cyc(1);
    `CHK(is_gpio, 1'b0)
    run <= 1'b1;
    rises(256);
    `CHK(cnt >= 31 && cnt <= 33, 1'b1)
    xfer(1'b1, 12'h004, 32'h70);
    rises(256);
    `CHK(cnt >= 31 && cnt <= 33, 1'b1)
    rd(12'h004, 32'h7b);
    run <= 1'b0;
    wait_cyc(8);
    `CHK(system_clock, 1'b0)
    xfer(1'b1, 12'h014, 32'h0);
    wait_cyc(1);
    `CHK(is_gpio, 1'b1)
    // a mid-run reset brings back the 8 MHz code and a quiet pin
    xfer(1'b1, 12'h000, 32'h40);
    presetn <= 1'b0;
    wait_cyc(3);
    presetn <= 1'b1;
    rd(12'h000, 32'h0);
    wait_cyc(4);
    rd(12'h004, 32'h6b);
    final_report();
  end
endmodule : tb_osc_source_select_ctrl
`default_nettype wire
